// ==== pkg/cpu8_params.svh ====
// Offsets, field positions, opcodes, vectors, reset values and timing counts
`ifndef CPU8_PARAMS_SVH
`define CPU8_PARAMS_SVH
`define TMR_CTRL_OFS   12'h000
`define TMR_COUNT_OFS  12'h004
`define CORE_STAT_OFS  12'h008
`define TMR_EN_BIT     0
`define TMR_FLAG_BIT   1
`define VEC_TIMER      16'hFFF8
`define VEC_IRQ        16'hFFFA
`define VEC_SWI        16'hFFFC
`define VEC_RESET      16'hFFFE
`define SP_RESET       8'h7F
`define CC_TOP_ONES    3'h7
`define OP_TAX         8'h97
`define OP_TXA         8'h9F
`define OP_TSTA        8'h4D
`define OP_TSTX        8'h5D
`define OP_STOP        8'h8E
`define OP_WAIT        8'h8F
`define OP_SWI         8'h83
`define OP_RTI         8'h80
`define LO_SUB         4'h0
`define LO_STA         4'h7
`define LO_STX         4'hF
`define LO_TST         4'hD
`define CYC_MIN        4'h1
`define CYC_TRAP       4'hA
`define CYC_RETURN     4'h9
`define STABILISE_CYC  11'h780
`define PRESCALE_LAST  3'h7
`endif

// ==== pkg/cpu8_pkg.sv ====
// Types shared by the core and its timer
package cpu8_pkg;
	typedef enum logic [3:0] {
		ST_VEC_A, ST_VEC_B, ST_VEC_C, ST_DECODE, ST_HI, ST_ADDR, ST_OPER,
		ST_PAD, ST_PUSH, ST_PULL, ST_WAITING, ST_HALTED, ST_STABLE
	} state_e;
	typedef enum logic [2:0] {M_INH, M_IMM, M_DIR, M_EXT, M_IX0, M_IX1, M_IX2} mode_e;
	typedef struct packed {logic h; logic i; logic n; logic z; logic c;} cc_s;
	typedef struct packed {
		state_e      st;
		logic [15:0] pc;
		logic [7:0]  a;
		logic [7:0]  x;
		logic [7:0]  sp;
		logic [7:0]  op;
		logic [7:0]  hi;
		cc_s         cc;
		logic [2:0]  idx;
		logic [3:0]  cnt;
		logic [3:0]  need;
		logic [15:0] vec;
		logic [10:0] stab;
		logic [2:0]  irq_sync;
		logic        irq_lvl;
		logic [15:0] mem_addr;
		logic        mem_rd;
		logic        mem_wr;
		logic [7:0]  mem_wdata;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} core_s;
	typedef struct packed {
		logic [2:0] pre;
		logic [7:0] count;
		logic       en;
		logic       flag;
	} tmr_s;
endpackage

// ==== pkg/timer_if.sv ====
// Control and status between the core and its timer
`timescale 1ns/1ps
interface timer_if;
	logic       prescale_clear;
	logic       irq_disable;
	logic       flag_clear;
	logic       en_write;
	logic       en_value;
	logic       count_write;
	logic [7:0] count_value;
	logic       osc_stopped;
	logic [7:0] count;
	logic       flag;
	logic       irq_en;
	modport core (output prescale_clear, irq_disable, flag_clear, en_write, en_value,
		count_write, count_value, osc_stopped, input count, flag, irq_en);
	modport timer (input prescale_clear, irq_disable, flag_clear, en_write, en_value,
		count_write, count_value, osc_stopped, output count, flag, irq_en);
endinterface

// ==== verilog/cpu8_timer.sv ====
// Timer with prescaler, down counter and zero flag
`timescale 1ns/1ps
`include "cpu8_params.svh"
module cpu8_timer (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Core side
	timer_if.timer   tif
);
	import cpu8_pkg::*;

	tmr_s q;      // Registered state
	tmr_s n;      // Next state
	logic tick;   // Prescaler wrap
	logic set;    // Count reached zero

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		n = q;
		tick = 1'b0;
		// Prescaler frozen while the oscillator is stopped
		if (tif.prescale_clear) begin
			n.pre = 3'h0;
		end else if (!tif.osc_stopped) begin
			n.pre = q.pre + 3'h1;
			tick = (q.pre == `PRESCALE_LAST);
		end
		set = tick && (q.count == 8'h01);
		if (tick) begin
			n.count = q.count - 8'h01;
		end
		// Software load wins over the decrement
		if (tif.count_write) begin
			n.count = tif.count_value;
		end
		// Set wins over clear so a zero crossing is never lost
		n.flag = (q.flag & ~tif.flag_clear) | set;
		if (tif.irq_disable) begin
			n.en = 1'b0;
		end else if (tif.en_write) begin
			n.en = tif.en_value;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign tif.count  = q.count;
	assign tif.flag   = q.flag;
	assign tif.irq_en = q.en;
endmodule // cpu8_timer

// ==== verilog/cpu8_core.sv ====
// 8-bit core: stores, subtract, test, transfers, trap, return and low power
`timescale 1ns/1ps
`include "cpu8_params.svh"
module cpu8_core (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// External interrupt pin, active low
	input  wire logic        irq_n,
	// Processor bus to program and data memory
	output logic      [15:0] mem_addr,
	output logic             mem_rd,
	output logic             mem_wr,
	output logic      [7:0]  mem_wdata,
	input  wire logic [7:0]  mem_rdata,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	import cpu8_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Negative and zero of a byte
	function automatic logic [1:0] nz(input logic [7:0] v);
		nz = {v[7], (v == 8'h00)};
	endfunction

	// Difference with borrow in bit 8
	function automatic logic [8:0] sub_c(input logic [7:0] a, input logic [7:0] m);
		logic [7:0] r;
		r = a - m;
		sub_c = {(~a[7] & m[7]) | (m[7] & r[7]) | (r[7] & ~a[7]), r};
	endfunction

	// Addressing mode from the opcode; anything unhandled is inherent
	function automatic mode_e mode_of(input logic [7:0] op);
		logic ok;
		ok = ((op[3:0] == `LO_SUB) && (op[7:4] >= 4'hA))
			|| (((op[3:0] == `LO_STA) || (op[3:0] == `LO_STX)) && (op[7:4] >= 4'hB))
			|| ((op[3:0] == `LO_TST) && ((op[7:4] == 4'h3) || (op[7:4] == 4'h6)
			|| (op[7:4] == 4'h7)));
		mode_of = M_INH;
		if (ok) begin
			// Column pattern shared by every memory form
			case (op[7:4])
				4'hA: mode_of = M_IMM;
				4'hB, 4'h3: mode_of = M_DIR;
				4'hC: mode_of = M_EXT;
				4'hD: mode_of = M_IX2;
				4'hE, 4'h6: mode_of = M_IX1;
				4'hF, 4'h7: mode_of = M_IX0;
				default: mode_of = M_INH;
			endcase
		end
	endfunction

	// Cycle count of each opcode, newer process
	function automatic logic [3:0] cycles_of(input logic [7:0] op);
		case (op)
			`OP_SWI: cycles_of = `CYC_TRAP;
			`OP_RTI: cycles_of = `CYC_RETURN;
			`OP_TSTA, `OP_TSTX: cycles_of = 4'h3;
			8'h3D, 8'h7D, 8'hC0, 8'hE0: cycles_of = 4'h4;
			8'hB7, 8'hBF, 8'hF7, 8'hFF: cycles_of = 4'h4;
			8'hB0, 8'hF0: cycles_of = 4'h3;
			8'h6D, 8'hD0, 8'hC7, 8'hCF, 8'hE7, 8'hEF: cycles_of = 4'h5;
			8'hD7, 8'hDF: cycles_of = 4'h6;
			default: cycles_of = 4'h2;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State and timer link

	core_s       q;       // Registered state
	core_s       n;       // Next state
	timer_if     tif();   // Timer control and status
	logic [3:0]  cur;     // Cycle number within the instruction
	logic        done;    // Instruction finished
	logic        access;  // Effective address ready
	logic [15:0] ea;      // Effective address
	logic [15:0] base;    // Address before indexing
	logic [8:0]  diff;    // Subtract result with borrow
	logic        tmr_req; // Timer wants service
	mode_e       mode;    // Mode of the fetched or held opcode

	cpu8_timer u_timer (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.tif     (tif)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		n = q;
		done = 1'b0;
		access = 1'b0;
		ea = 16'h0000;
		base = 16'h0000;
		diff = 9'h000;
		n.mem_rd = 1'b0;
		n.mem_wr = 1'b0;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		tif.prescale_clear = 1'b0;
		tif.irq_disable = 1'b0;
		tif.flag_clear = 1'b0;
		tif.en_write = 1'b0;
		tif.en_value = pwdata[`TMR_EN_BIT];
		tif.count_write = 1'b0;
		tif.count_value = pwdata[7:0];
		// Timer stays frozen only while the oscillator is off
		tif.osc_stopped = (q.st == ST_HALTED);
		tmr_req = tif.flag & tif.irq_en;
		cur = (q.st == ST_DECODE) ? 4'h1 : q.cnt + 4'h1;
		n.cnt = cur;
		mode = mode_of((q.st == ST_DECODE) ? mem_rdata : q.op);

		// Pin synchroniser; the level moves once stages two and three agree
		n.irq_sync = {q.irq_sync[1:0], irq_n};
		if (q.irq_sync[1] == q.irq_sync[2]) begin
			n.irq_lvl = q.irq_sync[2];
		end

		case (q.st)
			// Vector high byte request
			ST_VEC_A: begin
				n.mem_addr = q.vec;
				n.mem_rd = 1'b1;
				n.st = ST_VEC_B;
			end
			// Vector low byte request
			ST_VEC_B: begin
				n.pc[15:8] = mem_rdata;
				n.mem_addr = q.vec + 16'h0001;
				n.mem_rd = 1'b1;
				n.st = ST_VEC_C;
			end
			ST_VEC_C: begin
				n.pc[7:0] = mem_rdata;
				done = 1'b1;
			end
			// Opcode arrives; PC already points past it
			ST_DECODE: begin
				n.op = mem_rdata;
				n.need = cycles_of(mem_rdata);
				if (mode == M_IX0) begin
					ea = {8'h00, q.x};
					access = 1'b1;
				end else if (mode != M_INH) begin
					// Operand or address byte next
					n.mem_addr = q.pc;
					n.mem_rd = 1'b1;
					n.pc = q.pc + 16'h0001;
					if (mode == M_IMM) begin
						n.st = ST_OPER;
					end else if ((mode == M_EXT) || (mode == M_IX2)) begin
						n.st = ST_HI;
					end else begin
						n.st = ST_ADDR;
					end
				end else begin
					done = 1'b1;
					case (mem_rdata)
						`OP_TAX: n.x = q.a;
						`OP_TXA: n.a = q.x;
						`OP_TSTA: {n.cc.n, n.cc.z} = nz(q.a);
						`OP_TSTX: {n.cc.n, n.cc.z} = nz(q.x);
						// Oscillator off; timer quietened first
						`OP_STOP: begin
							done = 1'b0;
							n.cc.i = 1'b0;
							tif.prescale_clear = 1'b1;
							tif.irq_disable = 1'b1;
							tif.flag_clear = 1'b1;
							n.st = ST_HALTED;
						end
						// Core idles, timer keeps counting
						`OP_WAIT: begin
							done = 1'b0;
							n.cc.i = 1'b0;
							n.st = ST_WAITING;
						end
						`OP_SWI: begin
							done = 1'b0;
							n.vec = `VEC_SWI;
							n.idx = 3'h0;
							n.st = ST_PUSH;
						end
						// First pull request
						`OP_RTI: begin
							done = 1'b0;
							n.sp = q.sp + 8'h01;
							n.mem_addr = {8'h00, n.sp};
							n.mem_rd = 1'b1;
							n.idx = 3'h0;
							n.st = ST_PULL;
						end
						default: done = 1'b1; // Unhandled opcodes act as one-byte no-ops
					endcase
				end
			end
			// High address byte of a wide form
			ST_HI: begin
				n.hi = mem_rdata;
				n.mem_addr = q.pc;
				n.mem_rd = 1'b1;
				n.pc = q.pc + 16'h0001;
				n.st = ST_ADDR;
			end
			// Last address byte; add X for indexed forms
			ST_ADDR: begin
				base = ((mode == M_EXT) || (mode == M_IX2)) ? {q.hi, mem_rdata}
					: {8'h00, mem_rdata};
				ea = ((mode == M_IX1) || (mode == M_IX2)) ? base + {8'h00, q.x} : base;
				access = 1'b1;
			end
			// Operand arrives
			ST_OPER: begin
				done = 1'b1;
				if (q.op[3:0] == `LO_SUB) begin
					diff = sub_c(q.a, mem_rdata);
					n.a = diff[7:0];
					n.cc.c = diff[8];
					{n.cc.n, n.cc.z} = nz(diff[7:0]);
				end else begin
					{n.cc.n, n.cc.z} = nz(mem_rdata);
				end
			end
			// Holds until the cycle count is met
			ST_PAD: done = 1'b1;
			// One stacked byte per cycle
			ST_PUSH: begin
				n.mem_addr = {8'h00, q.sp};
				n.mem_wr = 1'b1;
				case (q.idx)
					3'h0: n.mem_wdata = q.pc[7:0];
					3'h1: n.mem_wdata = q.pc[15:8];
					3'h2: n.mem_wdata = q.x;
					3'h3: n.mem_wdata = q.a;
					default: n.mem_wdata = {`CC_TOP_ONES, q.cc};
				endcase
				n.sp = q.sp - 8'h01;
				n.idx = q.idx + 3'h1;
				if (q.idx == 3'h4) begin
					n.cc.i = 1'b1;
					n.st = ST_VEC_A;
				end
			end
			// One pulled byte per cycle
			ST_PULL: begin
				case (q.idx)
					3'h0: n.cc = mem_rdata[4:0];
					3'h1: n.a = mem_rdata;
					3'h2: n.x = mem_rdata;
					3'h3: n.pc[15:8] = mem_rdata;
					default: n.pc[7:0] = mem_rdata;
				endcase
				if (q.idx == 3'h4) begin
					done = 1'b1;
				end else begin
					n.sp = q.sp + 8'h01;
					n.mem_addr = {8'h00, n.sp};
					n.mem_rd = 1'b1;
					n.idx = q.idx + 3'h1;
				end
			end
			// Pin wins over the timer when both are asking
			ST_WAITING: begin
				if (!q.irq_lvl) begin
					n.vec = `VEC_IRQ;
					n.need = `CYC_MIN;
					n.idx = 3'h0;
					n.st = ST_PUSH;
				end else if (tmr_req) begin
					n.vec = `VEC_TIMER;
					n.need = `CYC_MIN;
					n.idx = 3'h0;
					n.st = ST_PUSH;
				end
			end
			// Only the pin can restart the oscillator
			ST_HALTED: begin
				if (!q.irq_lvl) begin
					n.stab = 11'h000;
					n.st = ST_STABLE;
				end
			end
			// Settling delay before the vector fetch
			ST_STABLE: begin
				n.stab = q.stab + 11'h001;
				if (q.stab == `STABILISE_CYC - 11'h001) begin
					n.vec = `VEC_IRQ;
					n.need = `CYC_MIN;
					n.idx = 3'h0;
					n.st = ST_PUSH;
				end
			end
			default: n.st = ST_PAD;
		endcase

		// Store writes now; subtract and test read the operand
		if (access) begin
			// Opcode of this instruction, never the one before it
			if (n.op[3:0] == `LO_STA) begin
				n.mem_addr = ea;
				n.mem_wr = 1'b1;
				n.mem_wdata = q.a;
				{n.cc.n, n.cc.z} = nz(q.a);
				done = 1'b1;
			end else if (n.op[3:0] == `LO_STX) begin
				n.mem_addr = ea;
				n.mem_wr = 1'b1;
				n.mem_wdata = q.x;
				{n.cc.n, n.cc.z} = nz(q.x);
				done = 1'b1;
			end else begin
				n.mem_addr = ea;
				n.mem_rd = 1'b1;
				n.st = ST_OPER;
			end
		end

		// Instruction boundary: pad, take an interrupt, or fetch
		if (done) begin
			if (cur < n.need) begin
				n.st = ST_PAD;
			end else if (!q.irq_lvl && !n.cc.i) begin
				n.vec = `VEC_IRQ;
				n.need = `CYC_MIN;
				n.idx = 3'h0;
				n.st = ST_PUSH;
			end else if (tmr_req && !n.cc.i) begin
				n.vec = `VEC_TIMER;
				n.need = `CYC_MIN;
				n.idx = 3'h0;
				n.st = ST_PUSH;
			end else begin
				n.mem_addr = n.pc;
				n.mem_rd = 1'b1;
				n.pc = n.pc + 16'h0001;
				n.st = ST_DECODE;
			end
		end

		// APB setup: decode and answer in the first access cycle
		if (psel && !penable) begin
			n.pready = 1'b1;
			n.prdata = 32'h0000_0000;
			if (paddr == `TMR_CTRL_OFS) begin
				n.prdata[`TMR_EN_BIT] = tif.irq_en;
				n.prdata[`TMR_FLAG_BIT] = tif.flag;
			end else if (paddr == `TMR_COUNT_OFS) begin
				n.prdata[7:0] = tif.count;
			end else if (paddr == `CORE_STAT_OFS) begin
				n.prdata[2:0] = {q.cc.i, (q.st == ST_HALTED), (q.st == ST_WAITING)};
			end else begin
				n.pslverr = 1'b1; // Unmapped address
			end
		end
		// APB write lands at the completing edge
		if (psel && penable && q.pready && pwrite && !q.pslverr) begin
			if (paddr == `TMR_CTRL_OFS) begin
				tif.en_write = 1'b1;
				if (pwdata[`TMR_FLAG_BIT]) begin
					tif.flag_clear = 1'b1;
				end
			end else if (paddr == `TMR_COUNT_OFS) begin
				tif.count_write = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register; reset starts at the reset vector
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.st <= ST_VEC_A;
			q.sp <= `SP_RESET;
			q.vec <= `VEC_RESET;
			q.cc.i <= 1'b1;
			q.irq_sync <= 3'h7;
			q.irq_lvl <= 1'b1;
		end else begin
			q <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign mem_addr  = q.mem_addr;
	assign mem_rd    = q.mem_rd;
	assign mem_wr    = q.mem_wr;
	assign mem_wdata = q.mem_wdata;
	assign prdata    = q.prdata;
	assign pready    = q.pready;
	assign pslverr   = q.pslverr;
endmodule // cpu8_core

// ==== bench/cpu8_core_checker.sv ====
// Port checker for the core, bound to its top module
`timescale 1ns/1ps
module cpu8_core_checker (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// Processor bus
	input wire logic [15:0] mem_addr,
	input wire logic        mem_rd,
	input wire logic        mem_wr,
	input wire logic [7:0]  mem_wdata,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////////
	// Reset vector is fetched high byte first
	reset_fetch_a: assert property ($rose(rst_n) |=> mem_rd && mem_addr == 16'hFFFE
		##1 mem_rd && mem_addr == 16'hFFFF) else $error("reset vector fetch wrong");
	// One byte access per cycle
	rw_excl_a: assert property (!(mem_rd && mem_wr)) else $error("read and write together");
	// Stacking is five bytes, never fewer or more
	push_run_a: assert property ($rose(mem_wr) ##1 mem_wr |=> mem_wr[*3] ##1 !mem_wr)
		else $error("stack burst length wrong");
	// Each stacked byte goes one below the last, in page zero
	push_down_a: assert property (mem_wr && $past(mem_wr) |->
		mem_addr == {8'h00, $past(mem_addr[7:0]) - 8'h01}) else $error("stack address wrong");
	// Last stacked byte is the flag byte with three ones on top
	cc_top_a: assert property (mem_wr ##1 mem_wr ##1 mem_wr ##1 mem_wr ##1 mem_wr |->
		mem_wdata[7:5] == 3'h7) else $error("flag byte top bits wrong");
	// Trap vector low byte follows its high byte
	vec_pair_a: assert property (mem_rd && mem_addr == 16'hFFFC |=>
		mem_rd && mem_addr == 16'hFFFD) else $error("trap vector order wrong");
	// Zero wait state slave
	apb_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
	// Ready is a single pulse
	ready_once_a: assert property (pready |=> !pready) else $error("ready too long");
	// Offsets above 0x008 are refused with zero data
	bad_addr_a: assert property (psel && !penable && paddr > 12'h008 |=>
		pslverr && prdata == 32'h0) else $error("unmapped access accepted");
	// Error only comes with ready
	err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
endmodule // cpu8_core_checker
bind cpu8_core cpu8_core_checker i_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
	.psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));

// ==== bench/cpu8_mem.sv ====
// Program and data memory model on the processor bus
`timescale 1ns/1ps
module cpu8_mem (
	// Clock
	input wire logic        ref_clk,
	// Processor bus
	input wire logic [15:0] mem_addr,
	input wire logic        mem_rd,
	input wire logic        mem_wr,
	input wire logic [7:0]  mem_wdata,
	output logic     [7:0]  mem_rdata
);
	logic [7:0] mem [65536]; // Whole address space
	logic [7:0] last = 8'h00; // Last byte read
	// Unselected: inverse of last byte, so stale data never looks valid
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;
	// Writes land at the edge
	always @(posedge ref_clk) begin
		if (mem_wr) mem[mem_addr] <= mem_wdata;
		if (mem_rd) last <= mem[mem_addr];
	end
endmodule // cpu8_mem

// ==== bench/cpu8_store_sub_trap_lowpower_ops_bench.sv ====
// Self-checking bench for the core
`timescale 1ns/1ps
`include "cpu8_params.svh"
module cpu8_store_sub_trap_lowpower_ops_bench;
	logic        ref_clk = 1'b0; // Core clock
	logic        rst_n = 1'b0;   // Reset, active low
	logic        irq_n = 1'b1;   // Interrupt pin, active low
	logic [15:0] mem_addr;       // Memory bus
	logic        mem_rd;
	logic        mem_wr;
	logic [7:0]  mem_wdata;
	logic [7:0]  mem_rdata;
	logic        psel = 1'b0;    // APB master
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] rd;             // Last read word
	logic        chk = 1'b0;     // Current read is noted
	int          n_fail = 0;
	int          tests_run = 0;
	logic [31:0] wq[$];          // Noted writes: mask, address, data
	logic [32:0] aq[$];          // Noted reads: error, data
	logic [7:0]  a1, r2, r3, a2, a3, cc;
	always #50 ref_clk = ~ref_clk;
	cpu8_core i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .irq_n(irq_n), .mem_addr(mem_addr),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	cpu8_mem i_mem (.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	////////////////////////////////////////////////////////////////////////////////
	task automatic fail(string what, logic [31:0] e, logic [31:0] s);
		n_fail++;
		$display("BAD %s expected %h seen %h", what, e, s);
	endtask
	task automatic stop_test();
		$display("counts: checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Note one write; mask hides bits no instruction here defines
	function automatic void nw(logic [15:0] a, logic [7:0] d, logic [7:0] m);
		wq.push_back({m, a, d});
	endfunction
	// Note a five byte stacking sequence
	function automatic void push5(logic [7:0] s, logic [15:0] pc, logic [7:0] x, logic [7:0] cc);
		nw({8'h00, s}, pc[7:0], 8'hFF);
		nw({8'h00, s - 8'h01}, pc[15:8], 8'hFF);
		nw({8'h00, s - 8'h02}, x, 8'hFF);
		nw({8'h00, s - 8'h03}, x, 8'hFF);
		nw({8'h00, s - 8'h04}, cc, 8'hEF);
	endfunction
	// One APB transfer, held until ready
	task automatic apb(logic w, logic [11:0] a, logic [32:0] e, logic c);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= e[31:0];
		if (c) aq.push_back(e);
		@(posedge ref_clk);
		penable <= 1'b1;
		chk <= c;
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		chk <= 1'b0;
		if (i == 20) begin
			fail("apb ready", 32'h1, 32'h0);
			stop_test();
		end
		@(posedge ref_clk);
	endtask
	// Read status until a bit shows, bounded
	task automatic poll(logic [31:0] m);
		int i;
		for (i = 0; i < 100; i++) begin
			apb(1'b0, `CORE_STAT_OFS, 33'h0, 1'b0);
			if ((rd & m) !== 32'h0) break;
		end
		if (i == 100) begin
			fail("status wait", m, rd);
			stop_test();
		end
	endtask
	// Wait until only n noted writes remain
	task automatic wait_q(int n);
		int i;
		for (i = 0; i < 5000 && wq.size() > n; i++) @(posedge ref_clk);
		if (wq.size() > n) begin
			fail("write count", n, wq.size());
			stop_test();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Watcher: compares each result with the oldest note
	always @(posedge ref_clk) begin
		logic [31:0] n;
		logic [32:0] e;
		if (mem_wr === 1'b1) begin
			n = wq.size() ? wq.pop_front() : 32'hFFFFFFFF;
			tests_run++;
			if ({mem_addr, mem_wdata & n[31:24]} !== {n[23:8], n[7:0] & n[31:24]})
				fail("mem write", n[23:0], {mem_addr, mem_wdata});
		end
		if (pready === 1'b1 && chk === 1'b1) begin
			e = aq.pop_front();
			tests_run++;
			if ({pslverr, prdata} !== e) fail("apb read", e[31:0], prdata);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: one program per pass, different subtrahends
	initial begin
		int k, i, t;
		logic [159:0] p;
		void'($urandom(98));
		for (k = 0; k < 4; k++) begin
			rst_n <= 1'b0;
			repeat (16) @(posedge ref_clk);
			a1 = 8'h80 | 8'($urandom & 32'h3F);
			r2 = 8'($urandom);
			r3 = k == 0 ? 8'($urandom) : k == 1 ? a1 : k == 2 ? a1 + 8'h01 : 8'h00;
			a2 = a1 - r2;
			a3 = a1 - r3;
			cc = {4'hE, 1'b1, a3[7], a3 == 8'h00, r3 > a1};
			p = {8'hA0, 8'h00 - a1, 8'h97, 8'hA0, r2, 8'hD7, 8'h02, 8'h00, 8'hEF, 8'h10,
				8'hDF, 8'h03, 8'h00, 8'h9F, 8'hE7, 8'h20, 8'hB0, 8'h40, 8'h9F, 8'h83};
			for (i = 0; i < 65536; i++) i_mem.mem[i] = 8'h9D;
			for (i = 0; i < 20; i++) i_mem.mem[16'h0100 + i] = p[159 - 8 * i -: 8];
			{i_mem.mem[16'hFFFE], i_mem.mem[16'hFFFF]} = 16'h0100;
			{i_mem.mem[16'hFFFC], i_mem.mem[16'hFFFD]} = 16'h0180;
			{i_mem.mem[16'hFFFA], i_mem.mem[16'hFFFB]} = 16'h01C0;
			i_mem.mem[16'h0040] = r3;
			{i_mem.mem[16'h0180], i_mem.mem[16'h0181]} = 16'h5D8F;
			i_mem.mem[16'h01C0] = 8'h8E;
			nw(16'h0200 + a1, a2, 8'hFF);
			nw(a1 + 16'h0010, a1, 8'hFF);
			nw(16'h0300 + a1, a1, 8'hFF);
			nw(a1 + 16'h0020, a1, 8'hFF);
			push5(8'h7F, 16'h0114, a1, cc);
			push5(8'h7A, 16'h0182, a1, {cc[7:4], 4'h4 | cc[0]});
			push5(8'h75, 16'h01C1, a1, {cc[7:4], 4'h4 | cc[0]});
			rst_n <= 1'b1;
			@(posedge ref_clk);
			apb(1'b1, `TMR_COUNT_OFS, 33'hFF, 1'b0);
			apb(1'b1, `TMR_CTRL_OFS, 33'h3, 1'b0);
			wait_q(10);
			poll(32'h1);
			apb(1'b0, `CORE_STAT_OFS, 33'h1, 1'b1);
			irq_n <= 1'b0;
			wait_q(9);
			// Let go once stacking starts, or the handler's halt would wake at once
			irq_n <= 1'b1;
			wait_q(5);
			poll(32'h2);
			apb(1'b0, `CORE_STAT_OFS, 33'h2, 1'b1);
			apb(1'b0, `TMR_CTRL_OFS, 33'h0, 1'b1);
			apb(1'b0, 12'h00C, {1'b1, 32'h0}, 1'b1);
			// Handler returns on the next entry instead of halting again
			i_mem.mem[16'h01C0] = 8'h80;
			// Wake from halt only after the settling delay
			irq_n <= 1'b0;
			for (t = 0; t < 3000 && mem_wr !== 1'b1; t++) @(posedge ref_clk);
			tests_run++;
			if (t < 1920 || t > 1950) fail("wake delay", 32'd1920, t);
			irq_n <= 1'b1;
			wait_q(0);
			// Return pulls the stacked flags, whose mask bit was clear
			repeat (20) @(posedge ref_clk);
			apb(1'b0, `CORE_STAT_OFS, 33'h0, 1'b1);
			$display("test %0d done", k);
		end
		stop_test();
	end
endmodule // cpu8_store_sub_trap_lowpower_ops_bench
